//--- hw/isd_top.sv
// Interrupt source detection, status flags and priority selection
`timescale 1ns/1ps
`include "isd_consts.svh"
module isd_top
   import isd_pkg::*;
#(
   parameter int EXT_LINES = 8,
   parameter int PER_SOURCES = 40
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic nmi_pin,
   input wire logic [EXT_LINES-1:0] irq_pins,
   input wire logic nonmask_edge_select,
   input wire logic [2*EXT_LINES-1:0] request_sense_control,
   input wire logic [EXT_LINES-1:0] request_enable_reg,
   input wire logic enable_write,
   input wire logic [`ISD_FIELD_COUNT*`ISD_LEVEL_W-1:0] priority_level_reg,
   input wire logic status_read,
   input wire logic status_write,
   input wire logic [EXT_LINES-1:0] status_write_data,
   input wire logic [PER_SOURCES-1:0] periph_flags,
   input wire logic [PER_SOURCES-1:0] periph_enables,
   input wire logic exc_entry,
   input wire isd_vector_t exc_vector,
   output logic [EXT_LINES-1:0] request_status_reg,
   output logic [EXT_LINES-1:0] enable_state,
   output logic nmi_req,
   output logic irq_req,
   output isd_vector_t irq_vector,
   output isd_level_t irq_level,
   output logic [15:0] irq_vaddr,
   output logic wake_req
);
   // Sense and enable are held here so that reset gives defined values
   logic [2*EXT_LINES-1:0] sense_r, sense_nxt;
   logic [EXT_LINES-1:0] enable_r, enable_nxt;
   logic [EXT_LINES-1:0] armed_r, armed_nxt;
   logic [EXT_LINES-1:0] flags, pin_high, clr;
   logic nmi_s1_r, nmi_s1_nxt, nmi_s2_r, nmi_s2_nxt, nmi_last_r, nmi_last_nxt;
   logic nmi_pend_r, nmi_pend_nxt, nmi_edge;
   logic irq_req_r, irq_req_nxt;
   isd_vector_t vector_r, vector_nxt;
   isd_level_t level_r, level_nxt;
   logic [15:0] vaddr_r, vaddr_nxt;
   logic wake_r, wake_nxt;
   logic cand_found;
   isd_vector_t cand_vec;
   isd_level_t cand_lvl;
   // Reserved peripheral slots never raise a request, whatever drives them
   localparam logic [39:0] PER_RESERVED = `ISD_PER_RESERVED;

   // Vector number to priority field index; groups of up to five vectors share one field
   function automatic isd_field_t field_of(input isd_vector_t v);
      isd_field_t f;
      f = 4'h0;
      case (v)
         7'd16: f = 4'h0;
         7'd17: f = 4'h1;
         7'd18, 7'd19: f = 4'h2;
         7'd20, 7'd21: f = 4'h3;
         7'd22, 7'd23: f = 4'h4;
         7'd24: f = 4'h5;
         7'd25: f = 4'h6;
         7'd27: f = 4'h7;
         7'd28, 7'd29: f = 4'h8;
         7'd32, 7'd33, 7'd34, 7'd35, 7'd36: f = 4'h9;
         7'd40, 7'd41, 7'd42, 7'd43: f = 4'ha;
         7'd44, 7'd45, 7'd46, 7'd47: f = 4'hb;
         7'd48, 7'd49, 7'd50, 7'd51, 7'd52: f = 4'hc;
         7'd56, 7'd57, 7'd58, 7'd59: f = 4'hd;
         default: f = 4'he;
      endcase
      return f;
   endfunction

   // Field index 0 sits in the top bits, matching high-to-low field order
   function automatic isd_level_t level_of(input isd_vector_t v,
                                           input logic [44:0] pl);
      isd_field_t f;
      f = field_of(v);
      return pl[(`ISD_FIELD_COUNT-1-int'(f))*`ISD_LEVEL_W +: `ISD_LEVEL_W];
   endfunction

   genvar g;
   generate
      for (g = 0; g < EXT_LINES; g++) begin : g_line
         isd_det_if det_if ();
         isd_pin_detect u_det (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .pin_raw(irq_pins[g]),
            .port(det_if.det)
         );
         assign det_if.sense = sense_r[2*g +: 2];
         assign det_if.clr = clr[g];
         assign flags[g] = det_if.flag;
         assign pin_high[g] = det_if.pin_high;
      end
   endgenerate

   // Flag clearing: read-one then write-zero, or exception entry
   always_comb begin
      armed_nxt = armed_r;
      for (int n = 0; n < EXT_LINES; n++) begin
         clr[n] = 1'b0;
         if (status_write && !status_write_data[n] && armed_r[n]) begin
            clr[n] = 1'b1;
         end
         if (exc_entry && exc_vector == `ISD_EXT_VECTOR_BASE + 7'(n) &&
             (sense_r[2*n +: 2] != `ISD_SENSE_LOW || pin_high[n])) begin
            clr[n] = 1'b1;
         end
         if (status_write) begin
            armed_nxt[n] = 1'b0;
         end
         if (status_read && flags[n]) begin
            armed_nxt[n] = 1'b1;
         end
      end
   end

   // Configuration capture; enables only change on their write strobe
   always_comb begin
      sense_nxt = request_sense_control;
      enable_nxt = enable_write ? request_enable_reg : enable_r;
   end

   // Non-maskable pin: synchronise, pick edge, hold until accepted
   always_comb begin
      nmi_s1_nxt = nmi_pin;
      nmi_s2_nxt = nmi_s1_r;
      nmi_last_nxt = nmi_s2_r;
      nmi_edge = nonmask_edge_select ? (~nmi_last_r & nmi_s2_r)
                                     : (nmi_last_r & ~nmi_s2_r);
      nmi_pend_nxt = nmi_edge |
         (nmi_pend_r & ~(exc_entry && exc_vector == `ISD_NMI_VECTOR));
   end

   // Scan ascending so a strict compare keeps the lower vector on ties
   always_comb begin
      isd_vector_t v;
      isd_level_t l;
      logic req;
      v = 7'h00;
      l = 3'h0;
      req = 1'b0;
      cand_found = 1'b0;
      cand_vec = 7'h00;
      cand_lvl = 3'h0;
      for (int i = 0; i < EXT_LINES; i++) begin
         v = `ISD_EXT_VECTOR_BASE + 7'(i);
         req = flags[i] & enable_r[i];
         l = level_of(v, priority_level_reg);
         if (req && (!cand_found || l > cand_lvl)) begin
            cand_found = 1'b1;
            cand_vec = v;
            cand_lvl = l;
         end
      end
      // Peripheral slots follow the pin lines, keeping the ascending order
      for (int j = 0; j < PER_SOURCES; j++) begin
         v = `ISD_PER_VECTOR_FIRST + 7'(j);
         req = periph_flags[j] & periph_enables[j] & ~PER_RESERVED[j];
         l = level_of(v, priority_level_reg);
         if (req && (!cand_found || l > cand_lvl)) begin
            cand_found = 1'b1;
            cand_vec = v;
            cand_lvl = l;
         end
      end
   end

   // Non-maskable request overrides every level and mask
   always_comb begin
      if (nmi_pend_r) begin
         irq_req_nxt = 1'b1;
         vector_nxt = `ISD_NMI_VECTOR;
         level_nxt = 3'h7;
         vaddr_nxt = `ISD_NMI_ADDR;
      end else begin
         irq_req_nxt = cand_found;
         vector_nxt = cand_vec;
         level_nxt = cand_lvl;
         vaddr_nxt = 16'(cand_vec) * `ISD_VEC_STRIDE;
      end
      // Wake ignores levels; standby exit only needs an enabled pin flag or a pending non-maskable request
      wake_nxt = nmi_pend_r | (|(flags & enable_r));
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sense_r <= `ISD_SENSE_RESET;
         enable_r <= `ISD_ENABLE_RESET;
         armed_r <= '0;
         nmi_s1_r <= `ISD_PIN_IDLE;
         nmi_s2_r <= `ISD_PIN_IDLE;
         nmi_last_r <= `ISD_PIN_IDLE;
         nmi_pend_r <= 1'b0;
         irq_req_r <= 1'b0;
         vector_r <= 7'h00;
         level_r <= 3'h0;
         vaddr_r <= 16'h0000;
         wake_r <= 1'b0;
      end else if (clk_en) begin
         sense_r <= sense_nxt;
         enable_r <= enable_nxt;
         armed_r <= armed_nxt;
         nmi_s1_r <= nmi_s1_nxt;
         nmi_s2_r <= nmi_s2_nxt;
         nmi_last_r <= nmi_last_nxt;
         nmi_pend_r <= nmi_pend_nxt;
         irq_req_r <= irq_req_nxt;
         vector_r <= vector_nxt;
         level_r <= level_nxt;
         vaddr_r <= vaddr_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign request_status_reg = flags;
   assign enable_state = enable_r;
   assign nmi_req = nmi_pend_r;
   assign irq_req = irq_req_r;
   assign irq_vector = vector_r;
   assign irq_level = level_r;
   assign irq_vaddr = vaddr_r;
   assign wake_req = wake_r;
endmodule

//--- hw/isd_consts.svh
// Constants of the interrupt source detect and prioritize block
// Behaviour
// - Nine external sources, each can wake device
// - Non-maskable request highest, always passed on
// - Edge select bit picks non-maskable edge
// - Per-pin sense: low, fall, rise, both
// - Per-pin enable bit gates request forwarding
// - External line levels set by priority fields
// - Status flags visible, software can clear them
// - Detection independent of pin direction setting
// - Flags set regardless of enable bits
// - Peripheral request needs flag and enable
// - Lower vector number wins by default
// - Module levels programmed; ties use vector order
// - Vectors 7 and 16-23, four-byte addresses
// - Shared priority fields; peripheral vectors 24-63
// - Sense code 00 low,01 fall,10 rise,11 both
// - Read-one-write-zero clear; clear on exception entry
// - Zero enable blocks request, one passes it
`ifndef ISD_CONSTS_SVH
`define ISD_CONSTS_SVH
`define ISD_SENSE_LOW 2'b00
`define ISD_SENSE_FALL 2'b01
`define ISD_SENSE_RISE 2'b10
`define ISD_SENSE_BOTH 2'b11
`define ISD_SENSE_RESET 16'h0000
`define ISD_ENABLE_RESET 8'h00
`define ISD_FLAG_RESET 1'b0
`define ISD_PIN_IDLE 1'b1
`define ISD_NMI_VECTOR 7'h07
`define ISD_NMI_ADDR 16'h001c
`define ISD_EXT_VECTOR_BASE 7'h10
`define ISD_EXT_ADDR_BASE 16'h0040
`define ISD_VEC_STRIDE 16'h0004
`define ISD_PER_VECTOR_FIRST 7'h18
`define ISD_PER_VECTOR_LAST 7'h3f
`define ISD_PER_RESERVED 40'h00e000e0c4
`define ISD_FIELD_COUNT 15
`define ISD_LEVEL_W 3
`endif

//--- hw/isd_pkg.sv
// Types of the interrupt source detect and prioritize block
package isd_pkg;
   typedef logic [1:0] isd_sense_t;
   typedef logic [2:0] isd_level_t;
   typedef logic [6:0] isd_vector_t;
   typedef logic [3:0] isd_field_t;
endpackage

//--- hw/isd_det_if.sv
// Carrier between the block top and one pin detector
`timescale 1ns/1ps
interface isd_det_if;
   import isd_pkg::*;
   isd_sense_t sense;
   logic clr;
   logic flag;
   logic pin_high;
   modport det (input sense, input clr, output flag, output pin_high);
   modport ctl (output sense, output clr, input flag, input pin_high);
endinterface

//--- hw/isd_pin_detect.sv
// One external request pin: synchroniser, sense detection and sticky flag
`timescale 1ns/1ps
`include "isd_consts.svh"
module isd_pin_detect
   import isd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic pin_raw,
   isd_det_if.det port
);
   logic sync1_r, sync1_nxt, sync2_r, sync2_nxt, last_r, last_nxt;
   logic flag_r, flag_nxt, hit;

   // Pin level is taken as is; the direction setting never enters here
   always_comb begin
      sync1_nxt = pin_raw;
      sync2_nxt = sync1_r;
      last_nxt = sync2_r;
      case (port.sense)
         `ISD_SENSE_LOW: hit = ~sync2_r;
         `ISD_SENSE_FALL: hit = last_r & ~sync2_r;
         `ISD_SENSE_RISE: hit = ~last_r & sync2_r;
         default: hit = last_r ^ sync2_r;
      endcase
      // Set wins over clear so an edge in the clearing cycle is kept
      flag_nxt = hit | (flag_r & ~port.clr);
   end

   // Idle high reset avoids a false falling edge after release
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= `ISD_PIN_IDLE;
         sync2_r <= `ISD_PIN_IDLE;
         last_r <= `ISD_PIN_IDLE;
         flag_r <= `ISD_FLAG_RESET;
      end else if (clk_en) begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         last_r <= last_nxt;
         flag_r <= flag_nxt;
      end
   end

   assign port.flag = flag_r;
   assign port.pin_high = sync2_r;
endmodule

//--- tb/isd_top_properties.sv
// Port-level checks of the interrupt source block
`timescale 1ns/1ps
module isd_top_properties
   import isd_pkg::*;
#(
   parameter int EXT_LINES = 8,
   parameter int PER_SOURCES = 40
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic nmi_pin,
   input wire logic nonmask_edge_select,
   input wire logic [EXT_LINES-1:0] request_enable_reg,
   input wire logic enable_write,
   input wire logic status_write,
   input wire logic [PER_SOURCES-1:0] periph_flags,
   input wire logic [PER_SOURCES-1:0] periph_enables,
   input wire logic exc_entry,
   input wire logic [EXT_LINES-1:0] request_status_reg,
   input wire logic [EXT_LINES-1:0] enable_state,
   input wire logic nmi_req,
   input wire logic irq_req,
   input wire isd_vector_t irq_vector,
   input wire isd_level_t irq_level,
   input wire logic [15:0] irq_vaddr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic [PER_SOURCES-1:0] pon_r;
   wire logic ext_on = |(request_status_reg & enable_state);
   // Request is a flop, so it answers to last cycle's gated flags
   always_ff @(posedge clk_sys) begin
      pon_r <= periph_flags & periph_enables;
   end
   AST_NMI_WIN: assert property (nmi_req && clk_en && !exc_entry |=>
      irq_req && irq_vector == 7'h07 && irq_level == 3'h7) else $error("nmi not presented");
   AST_VADDR: assert property (irq_req |-> irq_vaddr == {7'h0, irq_vector, 2'h0})
      else $error("vector address wrong");
   AST_EXT_ON: assert property (ext_on && clk_en && !exc_entry && !status_write |=> irq_req)
      else $error("enabled flag not presented");
   AST_BLOCK: assert property (!ext_on && !(|(periph_flags & periph_enables)) && !nmi_req
      && clk_en |=> !irq_req) else $error("request without source");
   AST_PERIPH: assert property (irq_req && irq_vector >= 7'h18 |-> pon_r[irq_vector - 7'h18])
      else $error("peripheral request not gated");
   AST_ENW: assert property (enable_write && clk_en |=> enable_state == $past(request_enable_reg))
      else $error("enable not loaded");
   AST_FLAG_FALL: assert property (|($past(request_status_reg) & ~request_status_reg) |->
      $past(status_write || exc_entry)) else $error("flag cleared without cause");
   AST_NMI_EDGE: assert property ($rose(nmi_pin) && nonmask_edge_select && clk_en |->
      ##[1:4] nmi_req) else $error("nmi edge missed");
   cover property (irq_req && irq_vector >= 7'h18);
   cover property (nmi_req && irq_req);
   cover property ($fell(request_status_reg[0]));
endmodule
bind isd_top isd_top_properties #(.EXT_LINES(EXT_LINES), .PER_SOURCES(PER_SOURCES)) chk_u (.*);

//--- tb/isd_cpu_model.sv
// Behavioural CPU core that takes presented requests
`timescale 1ns/1ps
module isd_cpu_model
   import isd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic ack_en,
   input wire logic irq_req,
   input wire isd_vector_t irq_vector,
   output logic exc_entry,
   output isd_vector_t exc_vector
);
   int gap = 0;
   initial exc_entry = 1'h0;
   initial exc_vector = 7'h0;
   // A quiet gap lets the flag clear land before the next take
   always @(posedge clk_sys) begin
      #10;
      if (gap == 0 && ack_en && irq_req) begin
         exc_entry = 1'h1;
         exc_vector = irq_vector;
         gap = 4;
      end else begin
         exc_entry = 1'h0;
         exc_vector = ~exc_vector;
         if (gap > 0) gap--;
      end
   end
endmodule

//--- tb/isd_top_test.sv
// Self-checking bench of the interrupt source block
`timescale 1ns/1ps
module isd_top_test;
   import isd_pkg::*;
   typedef struct {logic [15:0] s; logic [7:0] p0, p1, en; logic [39:0] pf, pe;
      logic [44:0] pl; logic [7:0] fl; logic rq; isd_vector_t v; isd_level_t lv;} isd_row_t;
   logic clk_sys = 1'h0, reset_n = 1'h0, clk_en = 1'h1, nmi_pin = 1'h1, nonmask_edge_select = 1'h0;
   logic enable_write = 1'h0, status_read = 1'h0, status_write = 1'h0, ack_en = 1'h0, exc_entry;
   logic [7:0] irq_pins = 8'hff, request_enable_reg = 8'h0, status_write_data = 8'h0;
   logic [15:0] request_sense_control = 16'h0, irq_vaddr;
   logic [44:0] priority_level_reg = 45'h0;
   logic [39:0] periph_flags = 40'h0, periph_enables = 40'h0;
   logic [7:0] request_status_reg, enable_state;
   logic nmi_req, irq_req, wake_req;
   isd_vector_t exc_vector, irq_vector;
   isd_level_t irq_level;
   int miscompares = 0, n_tests = 0;
   isd_row_t rows[10] = '{
      '{16'h0, 8'hff, 8'hfe, 8'h1, 40'h0, 40'h0, 45'h0, 8'h1, 1'h1, 7'h10, 3'h0},
      '{16'h4, 8'hff, 8'hfd, 8'h2, 40'h0, 40'h0, 45'h0, 8'h2, 1'h1, 7'h11, 3'h0},
      '{16'h20, 8'hfb, 8'hff, 8'h4, 40'h0, 40'h0, 45'h0, 8'h4, 1'h1, 7'h12, 3'h0},
      '{16'hc0, 8'hff, 8'hf7, 8'h8, 40'h0, 40'h0, 45'h0, 8'h8, 1'h1, 7'h13, 3'h0},
      '{16'h0, 8'hff, 8'hfe, 8'h0, 40'h0, 40'h0, 45'h0, 8'h1, 1'h0, 7'h0, 3'h0},
      '{16'h0, 8'hff, 8'h7e, 8'h81, 40'h0, 40'h0, 45'h140000000, 8'h81, 1'h1, 7'h17, 3'h5},
      '{16'h0, 8'hff, 8'hfc, 8'h3, 40'h0, 40'h0, 45'h0, 8'h3, 1'h1, 7'h10, 3'h0},
      '{16'h0, 8'hff, 8'hff, 8'h0, 40'h10001, 40'h10001, 45'h3000, 8'h0, 1'h1, 7'h28, 3'h3},
      '{16'h0, 8'hff, 8'hff, 8'h0, 40'h2, 40'h0, 45'h0, 8'h0, 1'h0, 7'h0, 3'h0},
      '{16'h0, 8'hff, 8'h7f, 8'h80, 40'h1, 40'h1, 45'h0, 8'h80, 1'h1, 7'h17, 3'h0}};
   always #50 clk_sys = ~clk_sys;
   isd_top dut_u (.*);
   isd_cpu_model cpu_u (.*);
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #10;
   endtask
   // Sense is applied before release so the first edges see the final mode
   task automatic rst(input logic [7:0] pins, input logic [15:0] sense, input logic [7:0] en);
      reset_n = 1'h0;
      irq_pins = pins;
      request_sense_control = sense;
      cyc(10);
      chk({request_status_reg, enable_state, nmi_req, irq_req}, 18'h0);
      reset_n = 1'h1;
      request_enable_reg = en;
      enable_write = 1'h1;
      cyc(1);
      enable_write = 1'h0;
      chk(enable_state, en);
   endtask
   initial begin
      #300000;
      miscompares++;
      final_report();
   end
   initial begin
      foreach (rows[i]) begin
         rst(rows[i].p0, rows[i].s, rows[i].en);
         priority_level_reg = rows[i].pl;
         periph_flags = rows[i].pf;
         periph_enables = rows[i].pe;
         cyc(5);
         irq_pins = rows[i].p1;
         cyc(6);
         chk(request_status_reg, rows[i].fl);
         chk(irq_req, rows[i].rq);
         chk(wake_req, |(rows[i].fl & rows[i].en));
         if (rows[i].rq) chk({irq_vector, irq_level}, {rows[i].v, rows[i].lv});
      end
      // Stale peripheral sources would mask the flag-only checks below
      periph_flags = 40'h0;
      periph_enables = 40'h0;
      priority_level_reg = 45'h0;
      rst(8'hff, 16'h0, 8'h1);
      clk_en = 1'h0;
      irq_pins = 8'hfe;
      cyc(6);
      chk({request_status_reg, irq_req}, 9'h0);
      clk_en = 1'h1;
      cyc(4);
      chk({request_status_reg, irq_req}, 9'h3);
      rst(8'hfe, 16'h1, 8'h1);
      cyc(5);
      status_write = 1'h1;
      cyc(1);
      status_write = 1'h0;
      cyc(2);
      chk(request_status_reg, 8'h1);
      status_read = 1'h1;
      cyc(1);
      status_read = 1'h0;
      status_write = 1'h1;
      cyc(1);
      status_write = 1'h0;
      cyc(2);
      chk({request_status_reg, irq_req}, 9'h0);
      rst(8'hfc, 16'h1, 8'h3);
      ack_en = 1'h1;
      cyc(20);
      chk({request_status_reg, irq_vector}, {8'h2, 7'h11});
      irq_pins = 8'hff;
      cyc(20);
      chk(request_status_reg, 8'h0);
      ack_en = 1'h0;
      nmi_pin = 1'h0;
      nonmask_edge_select = 1'h1;
      rst(8'hfe, 16'h0, 8'h1);
      priority_level_reg = {3'h7, 42'h0};
      cyc(5);
      nmi_pin = 1'h1;
      cyc(6);
      chk({nmi_req, irq_vector, irq_level}, {1'h1, 7'h07, 3'h7});
      ack_en = 1'h1;
      cyc(12);
      ack_en = 1'h0;
      chk(nmi_req, 1'h0);
      nonmask_edge_select = 1'h0;
      nmi_pin = 1'h0;
      cyc(6);
      chk(nmi_req, 1'h1);
      final_report();
   end
endmodule
